// File: pkg/tds_pkg.sv
// constants, register map and types of the trigger delay and strobe block
// assumes a single 10 MHz clock; widths of the camera model bus are
// supplied by the top module
package tds_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int CLK_MHZ = CLK_HZ / 1_000_000;
  localparam int UNIT_NS = 30_000;
  localparam int FIX_A_NS = 122_000;
  localparam int FIX_B_NS = 120_000;
  localparam int TICK_NS = 10_000;
  localparam int UNIT_CYC = (UNIT_NS * CLK_MHZ + 999) / 1000;
  localparam int FIX_CYC = ((FIX_A_NS + FIX_B_NS) * CLK_MHZ + 999) / 1000;
  localparam int TICK_CYC = (TICK_NS * CLK_MHZ + 999) / 1000;
  localparam int TICK_W = 7;
  localparam int TD_W = 18;
  localparam int LEN_W = 20;
  // ----------------------------------------------------------------
  // settings, ranges and reset values
  // ----------------------------------------------------------------
  localparam int DCNT_W = 10;
  localparam int DCNT_MIN_WIDE = -4;
  localparam int DCNT_MIN_NARROW = 0;
  localparam int DCNT_RST = 0;
  localparam int SDLY_W = 7;
  localparam int SDLY_MAX = 100;
  localparam int SDLY_RST = 0;
  localparam int SW_W = 10;
  localparam int SW_MIN = 4;
  localparam int SW_MAX = 1000;
  localparam int SW_RST = 500;
  localparam int STRB_MIN = 1;
  localparam int STRB_RST = 10;
  localparam int LMAP_W = 3;
  localparam int NMAP = 1 << LMAP_W;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STRB = 8'h04;
  localparam logic [7:0] A_SDLY = 8'h08;
  localparam logic [7:0] A_SW = 8'h0C;
  localparam logic [7:0] A_LMAP = 8'h10;
  localparam logic [7:0] A_STAT = 8'h14;
  localparam logic [7:0] A_CDLY = 8'h20;
  localparam logic [7:0] A_CID = 8'h40;
  localparam logic [7:0] A_CAM_MASK = 8'hE3;
  localparam int CAM_IDX_LSB = 2;
  localparam int CAM_IDX_W = 3;
  localparam int CTRL_SEL = 0;
  localparam int CTRL_NEG = 1;
  localparam int CDLY_HS = 16;
  localparam int STAT_STRB = 8;
  localparam int STAT_SHUT = 16;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {PS_IDLE, PS_WAIT, PS_ON} tds_pst_t;
endpackage

// File: pkg/tds_shut_if.sv
// settings and result of one exposure-end pulse generator
// assumes the controller drives start as a one-cycle pulse
`timescale 1ns/1ns
interface tds_shut_if;
  logic start;
  logic [tds_pkg::SDLY_W-1:0] dly;
  logic [tds_pkg::SW_W-1:0] width;
  logic neg;
  logic out;
  logic busy;
  modport ctrl (output start, dly, width, neg, input out, busy);
  modport gen (input start, dly, width, neg, output out, busy);
endinterface

// File: design/tds_sync.sv
// three-stage pin synchroniser with agreement filter
// assumes inputs are asynchronous to sys_clk
`timescale 1ns/1ns
module tds_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // pins in, filtered levels out
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] agree;

  assign agree = s2_q ~^ s3_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      dout <= '0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // a change only counts once stages two and three agree
      dout <= (dout & ~agree) | (s3_q & agree);
    end
  end
endmodule

// File: design/tds_pulse.sv
// exposure-end pulse generator for one processing line
// assumes settings are already clamped to their legal ranges
`timescale 1ns/1ns
module tds_pulse (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // settings and pulse
  tds_shut_if.gen bus
);
  tds_pkg::tds_pst_t st_q;
  logic [tds_pkg::SW_W-1:0] cnt_q;
  logic [tds_pkg::SW_W-1:0] w_q;
  logic [tds_pkg::SDLY_W-1:0] d_q;
  logic [tds_pkg::TICK_W-1:0] pre_q;
  logic tick;
  logic last;
  logic [tds_pkg::LEN_W-1:0] on_len_q;
  logic [tds_pkg::LEN_W-1:0] wt_len_q;

  // ----------------------------------------------------------------
  // local 10 us divider, restarted per pulse so timing is exact
  // ----------------------------------------------------------------
  assign tick = pre_q == tds_pkg::TICK_W'(tds_pkg::TICK_CYC - 1);
  assign last = tick && cnt_q == tds_pkg::SW_W'(1);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= '0;
    end else if (st_q == tds_pkg::PS_IDLE || tick) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + tds_pkg::TICK_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // sequence: idle, delay, active
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= tds_pkg::PS_IDLE;
      cnt_q <= '0;
      w_q <= '0;
      d_q <= '0;
    end else begin
      unique case (st_q)
        tds_pkg::PS_IDLE: begin
          // a start while busy is dropped, the pulse is not restarted
          if (bus.start) begin
            w_q <= bus.width;
            d_q <= bus.dly;
            if (bus.dly == '0) begin
              st_q <= tds_pkg::PS_ON;
              cnt_q <= bus.width;
            end else begin
              st_q <= tds_pkg::PS_WAIT;
              cnt_q <= tds_pkg::SW_W'(bus.dly);
            end
          end
        end
        tds_pkg::PS_WAIT: begin
          if (last) begin
            st_q <= tds_pkg::PS_ON;
            cnt_q <= w_q;
          end else if (tick) begin
            cnt_q <= cnt_q - tds_pkg::SW_W'(1);
          end
        end
        tds_pkg::PS_ON: begin
          if (last) begin
            st_q <= tds_pkg::PS_IDLE;
          end else if (tick) begin
            cnt_q <= cnt_q - tds_pkg::SW_W'(1);
          end
        end
      endcase
    end
  end

  assign bus.out = (st_q == tds_pkg::PS_ON) ^ bus.neg;
  assign bus.busy = st_q != tds_pkg::PS_IDLE;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      on_len_q <= '0;
      wt_len_q <= '0;
    end else begin
      on_len_q <= (st_q == tds_pkg::PS_ON) ?
        on_len_q + tds_pkg::LEN_W'(1) : '0;
      wt_len_q <= (st_q == tds_pkg::PS_WAIT) ?
        wt_len_q + tds_pkg::LEN_W'(1) :
        (st_q == tds_pkg::PS_ON) ? wt_len_q : '0;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_on_rise;
    $rose(st_q == tds_pkg::PS_ON);
  endsequence

  shut_delay_a: assert property (
    s_on_rise |-> int'(wt_len_q) == int'(d_q) * tds_pkg::TICK_CYC)
    else $error("exposure-end delay differs from setting");
  shut_width_a: assert property (
    $fell(st_q == tds_pkg::PS_ON) |->
      int'(on_len_q) == int'(w_q) * tds_pkg::TICK_CYC)
    else $error("exposure-end width differs from setting");
  shut_pol_a: assert property (
    s_on_rise |-> bus.out != bus.neg)
    else $error("exposure-end level wrong for polarity");
endmodule

// File: design/tds_top.sv
// trigger delay, strobe trigger and exposure-end timing, APB slave
// assumes one 10 MHz clock, pins asynchronous, APB master on sys_clk
//
// Function
// - per camera, exposure starts a programmed count of 30 us after trigger
// - total delay is count times 30 us plus 122 us plus 120 us
// - a capture during a running strobe pulse gets no strobe pulse of its own
// - strobe and exposure-end never share the line; a setting picks one
// - exposure-end output follows the end of camera exposure
// - exposure-end outputs are indexed by processing line, not camera
// - eight cameras on the large variant, four on the small ones
// - per-camera high-speed transmission option is selectable
// - each port reports attached camera model, or disconnected
// - exposure-end turns on 0 to 1000 us after exposure, 10 us steps
// - exposure-end pulse lasts 40 to 10000 us, 10 us steps, default 5000
// - exposure-end polarity selectable, positive by default
`timescale 1ns/1ns
module tds_top #(
  parameter int NCAM = 8,
  parameter int NLINE = 8,
  parameter bit WIDE = 1'b1,
  parameter int MODEL_W = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tds_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // camera side pins
  input wire logic [NCAM-1:0] trig_in,
  input wire logic [NCAM-1:0] cam_expo_end,
  input wire logic [NCAM-1:0] cam_present,
  input wire logic [NCAM*MODEL_W-1:0] cam_model,
  output logic [NCAM-1:0] cam_expo_start,
  output logic [NCAM-1:0] cam_hs_mode,
  // shared strobe / exposure-end lines
  output logic [NLINE-1:0] out_line
);
  localparam int SYNC_W = NCAM * (3 + MODEL_W);
  localparam int DCNT_MIN = WIDE ? tds_pkg::DCNT_MIN_WIDE :
    tds_pkg::DCNT_MIN_NARROW;
  localparam int CAM_IDX_W_L = tds_pkg::CAM_IDX_W;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic int clamp(input int v, input int lo, input int hi);
    if (v < lo) begin
      return lo;
    end
    if (v > hi) begin
      return hi;
    end
    return v;
  endfunction

  // whole trigger-to-exposure time in clock cycles
  function automatic logic [tds_pkg::TD_W-1:0] load_cyc(
    input logic signed [tds_pkg::DCNT_W-1:0] c);
    int v;
    v = int'(c) * tds_pkg::UNIT_CYC + tds_pkg::FIX_CYC;
    return tds_pkg::TD_W'(v);
  endfunction

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] sy;
  logic [NCAM-1:0] trig_s;
  logic [NCAM-1:0] end_s;
  logic [NCAM-1:0] pres_s;
  logic [NCAM*MODEL_W-1:0] model_s;
  logic [NCAM-1:0] trig_p_q;
  logic [NCAM-1:0] end_p_q;
  logic [NCAM-1:0] trig_rise;
  logic [tds_pkg::NMAP-1:0] end_rise;
  logic [1:0] ctrl_q;
  logic [tds_pkg::SW_W-1:0] strb_w_q;
  logic [tds_pkg::SDLY_W-1:0] sdly_q;
  logic [tds_pkg::SW_W-1:0] sw_q;
  logic [NLINE*tds_pkg::LMAP_W-1:0] lmap_q;
  logic signed [tds_pkg::DCNT_W-1:0] dcnt_q [NCAM];
  logic [NCAM-1:0] hs_q;
  logic [tds_pkg::TD_W-1:0] td_q [NCAM];
  logic [NCAM-1:0] start_q;
  logic [tds_pkg::SW_W-1:0] sc_q [NCAM];
  logic [NCAM-1:0] strb;
  logic [NCAM-1:0] td_busy;
  logic [NLINE-1:0] strb_ln;
  logic [NLINE-1:0] ev_line;
  logic [NLINE-1:0] shut_o;
  logic [NLINE-1:0] shut_busy;
  logic [tds_pkg::TICK_W-1:0] tk_q;
  logic tick;
  logic [CAM_IDX_W_L-1:0] cidx;
  logic cam_hit;
  logic [31:0] rd_d;
  logic err_d;
  logic wr;

  // ----------------------------------------------------------------
  // pin synchronisers and edges
  // ----------------------------------------------------------------
  tds_sync #(.W(SYNC_W)) u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .din({cam_model, cam_present, cam_expo_end, trig_in}),
    .dout(sy)
  );

  assign trig_s = sy[NCAM-1:0];
  assign end_s = sy[2*NCAM-1:NCAM];
  assign pres_s = sy[3*NCAM-1:2*NCAM];
  assign model_s = sy[SYNC_W-1:3*NCAM];
  assign trig_rise = trig_s & ~trig_p_q;
  assign end_rise = tds_pkg::NMAP'(end_s & ~end_p_q);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_p_q <= '0;
      end_p_q <= '0;
    end else begin
      trig_p_q <= trig_s;
      end_p_q <= end_s;
    end
  end

  // ----------------------------------------------------------------
  // 10 us enable for the strobe width
  // ----------------------------------------------------------------
  assign tick = tk_q == tds_pkg::TICK_W'(tds_pkg::TICK_CYC - 1);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tk_q <= '0;
    end else begin
      tk_q <= tick ? '0 : tk_q + tds_pkg::TICK_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  assign cidx = paddr[tds_pkg::CAM_IDX_LSB +: CAM_IDX_W_L];
  assign cam_hit = int'(cidx) < NCAM;

  always_comb begin
    rd_d = '0;
    err_d = 1'b0;
    if ((paddr & tds_pkg::A_CAM_MASK) == tds_pkg::A_CDLY) begin
      err_d = !cam_hit;
      if (cam_hit) begin
        rd_d[tds_pkg::DCNT_W-1:0] = dcnt_q[cidx];
        rd_d[tds_pkg::CDLY_HS] = hs_q[cidx];
      end
    end else if ((paddr & tds_pkg::A_CAM_MASK) == tds_pkg::A_CID) begin
      err_d = !cam_hit || pwrite;
      if (cam_hit && pres_s[cidx]) begin
        rd_d[MODEL_W-1:0] = model_s[cidx*MODEL_W +: MODEL_W];
      end
    end else begin
      unique case (paddr)
        tds_pkg::A_CTRL: rd_d[1:0] = ctrl_q;
        tds_pkg::A_STRB: rd_d[tds_pkg::SW_W-1:0] = strb_w_q;
        tds_pkg::A_SDLY: rd_d[tds_pkg::SDLY_W-1:0] = sdly_q;
        tds_pkg::A_SW: rd_d[tds_pkg::SW_W-1:0] = sw_q;
        tds_pkg::A_LMAP: rd_d[NLINE*tds_pkg::LMAP_W-1:0] = lmap_q;
        tds_pkg::A_STAT: begin
          err_d = pwrite;
          rd_d[NCAM-1:0] = td_busy;
          rd_d[tds_pkg::STAT_STRB +: NCAM] = strb;
          rd_d[tds_pkg::STAT_SHUT +: NLINE] = shut_busy;
        end
        default: err_d = 1'b1;
      endcase
    end
  end

  assign pready = 1'b1;
  assign pslverr = psel && penable && err_d;
  assign wr = psel && penable && pwrite && !err_d;

  // read data is captured in the setup cycle, so it is a flop output
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_d;
    end
  end

  // ----------------------------------------------------------------
  // registers; out-of-range writes are clamped, not refused
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= '0;
      strb_w_q <= tds_pkg::SW_W'(tds_pkg::STRB_RST);
      sdly_q <= tds_pkg::SDLY_W'(tds_pkg::SDLY_RST);
      sw_q <= tds_pkg::SW_W'(tds_pkg::SW_RST);
      lmap_q <= '0;
    end else if (wr) begin
      unique case (paddr)
        tds_pkg::A_CTRL: ctrl_q <= pwdata[tds_pkg::CTRL_NEG:0];
        tds_pkg::A_STRB: strb_w_q <= tds_pkg::SW_W'(clamp(
          int'(pwdata[15:0]), tds_pkg::STRB_MIN, tds_pkg::SW_MAX));
        tds_pkg::A_SDLY: sdly_q <= tds_pkg::SDLY_W'(clamp(
          int'(pwdata[15:0]), 0, tds_pkg::SDLY_MAX));
        tds_pkg::A_SW: sw_q <= tds_pkg::SW_W'(clamp(
          int'(pwdata[15:0]), tds_pkg::SW_MIN, tds_pkg::SW_MAX));
        tds_pkg::A_LMAP: lmap_q <= pwdata[NLINE*tds_pkg::LMAP_W-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hs_q <= '0;
      for (int c = 0; c < NCAM; c++) begin
        dcnt_q[c] <= tds_pkg::DCNT_W'(tds_pkg::DCNT_RST);
      end
    end else if (wr &&
        (paddr & tds_pkg::A_CAM_MASK) == tds_pkg::A_CDLY) begin
      hs_q[cidx] <= pwdata[tds_pkg::CDLY_HS];
      dcnt_q[cidx] <= tds_pkg::DCNT_W'(clamp(
        int'($signed(pwdata[tds_pkg::DCNT_W-1:0])), DCNT_MIN,
        (1 << (tds_pkg::DCNT_W - 1)) - 1));
    end
  end

  assign cam_hs_mode = hs_q;

  // ----------------------------------------------------------------
  // trigger delay and strobe per camera
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      start_q <= '0;
      for (int c = 0; c < NCAM; c++) begin
        td_q[c] <= '0;
        sc_q[c] <= '0;
      end
    end else begin
      for (int c = 0; c < NCAM; c++) begin
        start_q[c] <= td_q[c] == tds_pkg::TD_W'(1);
        if (trig_rise[c] && td_q[c] == '0) begin
          td_q[c] <= load_cyc(dcnt_q[c]);
        end else if (td_q[c] != '0) begin
          td_q[c] <= td_q[c] - tds_pkg::TD_W'(1);
        end
        // a new exposure during a strobe pulse does not restart the pulse
        if (start_q[c] && sc_q[c] == '0) begin
          sc_q[c] <= strb_w_q;
        end else if (tick && sc_q[c] != '0) begin
          sc_q[c] <= sc_q[c] - tds_pkg::SW_W'(1);
        end
      end
    end
  end

  always_comb begin
    for (int c = 0; c < NCAM; c++) begin
      strb[c] = sc_q[c] != '0;
      td_busy[c] = td_q[c] != '0;
    end
  end

  assign cam_expo_start = start_q;
  assign strb_ln = NLINE'(strb);

  // ----------------------------------------------------------------
  // exposure-end pulse per processing line
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < NLINE; i++) begin
      ev_line[i] = end_rise[lmap_q[i*tds_pkg::LMAP_W +: tds_pkg::LMAP_W]];
    end
  end

  for (genvar i = 0; i < NLINE; i++) begin : g_ln
    tds_shut_if u_if ();
    assign u_if.start = ev_line[i];
    assign u_if.dly = sdly_q;
    assign u_if.width = sw_q;
    assign u_if.neg = ctrl_q[tds_pkg::CTRL_NEG];
    assign shut_o[i] = u_if.out;
    assign shut_busy[i] = u_if.busy;
    tds_pulse u_pulse (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .bus(u_if.gen)
    );
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_line <= '0;
    end else begin
      out_line <= ctrl_q[tds_pkg::CTRL_SEL] ? shut_o : strb_ln;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  line_excl_a: assert property (
    ##1 out_line == ($past(ctrl_q[tds_pkg::CTRL_SEL]) ?
      $past(shut_o) : $past(strb_ln)))
    else $error("shared line shows the unselected signal");

  for (genvar c = 0; c < NCAM; c++) begin : g_chk
    sequence s_acc;
      trig_rise[c] && td_q[c] == '0;
    endsequence
    sequence s_fire;
      td_q[c] == tds_pkg::TD_W'(1) ##1 start_q[c] ##1 !start_q[c];
    endsequence

    delay_load_a: assert property (
      s_acc |=> td_q[c] == load_cyc($past(dcnt_q[c])))
      else $error("trigger delay loaded with wrong length");
    trig_ignore_a: assert property (
      trig_rise[c] && td_q[c] > tds_pkg::TD_W'(1) |=>
        td_q[c] == $past(td_q[c]) - tds_pkg::TD_W'(1))
      else $error("trigger restarted a running delay");
    expo_fire_a: assert property (
      td_q[c] == tds_pkg::TD_W'(1) |-> s_fire)
      else $error("exposure start not one cycle at delay end");
    count_range_a: assert property (
      int'(dcnt_q[c]) >= DCNT_MIN)
      else $error("delay count below variant minimum");
    strobe_keep_a: assert property (
      strb[c] && start_q[c] && !tick |=> sc_q[c] == $past(sc_q[c]))
      else $error("strobe pulse restarted by new exposure");
    cam_id_a: assert property (
      psel && !penable && !pwrite && !pres_s[c] &&
      paddr == (tds_pkg::A_CID | tds_pkg::ADDR_W'(c << 2)) |=>
        prdata == '0)
      else $error("disconnected port reports a model");
  end
endmodule

// File: dv/tds_cam_model.sv
// cameras and trigger source facing the timing block
// assumes one line per camera and fire held high for several cycles
`timescale 1ns/1ns
module tds_cam_model #(
  parameter int NCAM = 8,
  parameter int MODEL_W = 8,
  parameter int EXPO = 20
) (
  // clock
  input wire logic sys_clk,
  // bench requests
  input wire logic [NCAM-1:0] fire,
  input wire logic [NCAM-1:0] attach,
  // device pins
  input wire logic [NCAM-1:0] expo_start,
  input wire logic [NCAM-1:0] strobe_busy,
  output logic [NCAM-1:0] trig,
  output logic [NCAM-1:0] expo_end,
  output logic [NCAM-1:0] present,
  output logic [NCAM*MODEL_W-1:0] model
);
  int cnt [NCAM];
  initial begin
    trig = '0;
    expo_end = '0;
    foreach (cnt[i]) cnt[i] = 0;
  end
  // ------------------------------------------------------------
  // trigger source and exposure
  // ------------------------------------------------------------
  // end pulse lasts 6 cycles so the agreement filter can see it
  always @(posedge sys_clk) begin
    for (int i = 0; i < NCAM; i++) begin
      trig[i] <= fire[i] & ~strobe_busy[i];
      if (expo_start[i]) cnt[i] <= EXPO + 6;
      else if (cnt[i] > 0) cnt[i] <= cnt[i] - 1;
      expo_end[i] <= (cnt[i] > 0 && cnt[i] <= 6);
    end
  end
  always_comb begin
    present = attach;
    for (int i = 0; i < NCAM; i++) begin
      model[i*MODEL_W +: MODEL_W] = MODEL_W'(8'hA0 + i);
    end
  end
endmodule

// File: dv/tds_top_tb.sv
// self-checking bench of the trigger delay and exposure-end block
// assumes the camera model above and a zero wait state APB slave
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module tds_top_tb;
  localparam int N = 8;
  localparam int EXPO = 20;
  logic sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd_q;
  logic pready, pslverr, err_q;
  logic [N-1:0] fire = '0, attach = 8'hFD;
  logic [N-1:0] trig_in, cam_expo_end, cam_present, cam_expo_start;
  logic [N-1:0] cam_hs_mode, out_line;
  logic [N*8-1:0] cam_model;
  int bad_count = 0, n_tests = 0, cyc = 0;
  always #50 sys_clk = ~sys_clk;
  tds_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .trig_in(trig_in),
    .cam_expo_end(cam_expo_end), .cam_present(cam_present),
    .cam_model(cam_model), .cam_expo_start(cam_expo_start),
    .cam_hs_mode(cam_hs_mode), .out_line(out_line));
  tds_cam_model #(.NCAM(N), .MODEL_W(8), .EXPO(EXPO)) cams (
    .sys_clk(sys_clk), .fire(fire), .attach(attach),
    .expo_start(cam_expo_start), .strobe_busy(out_line), .trig(trig_in),
    .expo_end(cam_expo_end), .present(cam_present), .model(cam_model));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // an idle edge first keeps two transfers from colliding in one step
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    xfer(1'b0, a, '0);
    `CHK(nm, e, rd_q)
  endtask
  // a retrigger at 200 cycles falls inside every delay used here
  task automatic shoot(input int c, input int n);
    int t, hits;
    fire[c] <= 1'b1;
    for (t = 0; t < n + 50; t++) begin
      @(posedge sys_clk);
      if (t == 8 || t == 208) fire[c] <= 1'b0;
      if (t == 200) fire[c] <= 1'b1;
      if (cam_expo_start[c] === 1'b1) break;
    end
    `CHK("delay", 1'b1, (t >= n + 2 && t <= n + 8))
    // strobe counter loads one edge after the start, the line one more
    @(posedge sys_clk);
    @(posedge sys_clk);
    `CHK("strobe", 1'b1, out_line[c])
    hits = 0;
    repeat (1200) begin
      @(posedge sys_clk);
      if (cam_expo_start[c] === 1'b1) hits++;
    end
    `CHK("retrig", 0, hits)
    `CHK("strobe end", 1'b0, out_line[c])
  endtask
  task automatic shut(input int c, input int ln, input int n);
    int t, w;
    logic [N-1:0] other;
    fire[c] <= 1'b1;
    t = 0;
    other = '0;
    while (out_line[ln] !== 1'b1 && t < n + 300) begin
      @(posedge sys_clk);
      t++;
      if (t == 8) fire[c] <= 1'b0;
    end
    `CHK("shut dly", 1'b1, (t >= n + EXPO + 104 && t <= n + EXPO + 116))
    w = 0;
    while (out_line[ln] === 1'b1 && w < 1000) begin
      @(posedge sys_clk);
      other |= out_line & ~(8'h01 << ln);
      w++;
    end
    `CHK("shut width", 4 * tds_pkg::TICK_CYC, w)
    `CHK("line index", 8'h00, other)
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      conclude();
    end
  end
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(tds_pkg::A_CTRL, 32'h00000000, "ctrl");
    rd(tds_pkg::A_SDLY, 32'h00000000, "sdly");
    rd(tds_pkg::A_SW, 32'h000001F4, "sw");
    rd(tds_pkg::A_CDLY, 32'h00000000, "cdly");
    rd(tds_pkg::A_CID, 32'h000000A0, "cid0");
    rd(tds_pkg::A_CID + 8'h04, 32'h00000000, "cid1");
    xfer(1'b1, tds_pkg::A_CID, 32'h00000001);
    `CHK("ro write", 1'b1, err_q)
    rd(tds_pkg::A_CDLY + 8'h1C, 32'h00000000, "cam7");
    xfer(1'b1, tds_pkg::A_CDLY, 32'h00000001);
    xfer(1'b1, tds_pkg::A_CDLY + 8'h04, 32'h000103FC);
    rd(tds_pkg::A_CDLY + 8'h04, 32'h000103FC, "neg count");
    `CHK("hs mode", 8'h02, cam_hs_mode)
    xfer(1'b1, tds_pkg::A_CDLY + 8'h0C, 32'h000003F0);
    rd(tds_pkg::A_CDLY + 8'h0C, 32'h000003FC, "clamp");
    // short pulses, so the lines are idle again before the line test
    xfer(1'b1, tds_pkg::A_SW, 32'h00000004);
    shoot(0, 2720);
    shoot(1, 1220);
    xfer(1'b1, tds_pkg::A_SDLY, 32'h00000001);
    xfer(1'b1, tds_pkg::A_LMAP, 32'h00000010);
    xfer(1'b1, tds_pkg::A_CTRL, 32'h00000001);
    shut(2, 1, 2420);
    xfer(1'b1, tds_pkg::A_CTRL, 32'h00000003);
    repeat (3) @(posedge sys_clk);
    `CHK("neg idle", 8'hFF, out_line)
    rd(tds_pkg::A_STAT, 32'h00000400, "stat");
    conclude();
  end
endmodule
